// ---- stxe_regs.svh ----
// Reset values and timing counts for the skip, table-read and XOR executor
`ifndef STXE_REGS_SVH
`define STXE_REGS_SVH

`define STXE_ACC_RST 8'h00
`define STXE_LATCH_RST 8'h00
`define STXE_ZERO_RST 1'b0
`define STXE_SKIP_TAKEN_CYCLES 2
`define STXE_SKIP_NOT_TAKEN_CYCLES 1
`define STXE_TABLE_READ_CYCLES 2
`define STXE_DATA_W 8
`define STXE_ROM_W 16
`define STXE_ROM_AW 13

`endif

// ---- stxe_pkg.sv ----
// Types shared by the skip, table-read and XOR executor
package stxe_pkg;

    typedef enum logic [3:0] {
        OP_NIBX = 4'h0,
        OP_SKZ = 4'h1,
        OP_SKZA = 4'h2,
        OP_SKBIT = 4'h3,
        OP_TRDC = 4'h4,
        OP_TRDL = 4'h5,
        OP_XORA = 4'h6,
        OP_XOR_TO_MEM = 4'h7,
        OP_XORI = 4'h8
    } stxe_op_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_TABLE = 2'b01,
        ST_DUMMY = 2'b10
    } stxe_state_t;

endpackage

// ---- stxe_logic_unit.sv ----
// Combinational data path: nibble exchange, XOR and skip conditions
`timescale 1ns/1ps
module stxe_logic_unit (
    input wire stxe_pkg::stxe_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] mem,
    input wire logic [7:0] imm,
    input wire logic [2:0] bit_sel,
    output logic [7:0] result,
    output logic skip_cond,
    output logic result_zero
);
    always_comb begin
        result = mem;
        skip_cond = 1'b0;
        unique case (op)
            stxe_pkg::OP_NIBX: result = {mem[3:0], mem[7:4]};
            stxe_pkg::OP_SKZ: skip_cond = (mem == 8'h00);
            stxe_pkg::OP_SKZA: skip_cond = (mem == 8'h00);
            stxe_pkg::OP_SKBIT: skip_cond = ~mem[bit_sel];
            stxe_pkg::OP_XORA: result = acc ^ mem;
            stxe_pkg::OP_XOR_TO_MEM: result = acc ^ mem;
            stxe_pkg::OP_XORI: result = acc ^ imm;
            default: result = mem;
        endcase
        result_zero = (result == 8'h00);
    end
endmodule

// ---- stxe_exec.sv ----
// Executor for nibble exchange, zero skips, table reads and XOR operations
// Function
// - Nibble exchange loads swapped byte into accumulator
// - Skip-if-zero skips on zero byte, two cycles
// - Taken skip discards fetched instruction, one dummy
// - Move-test copies byte to accumulator, skips zero
// - Bit test skips when selected bit clear
// - Current-page table read: low byte memory, high latch
// - Last-page table read uses top page
// - XOR memory into accumulator, zero flag only
// - XOR result written to memory, accumulator kept
// - XOR immediate into accumulator, zero flag only
`timescale 1ns/1ps
`include "stxe_regs.svh"
module stxe_exec #(
    parameter int ROM_AW = `STXE_ROM_AW
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic op_valid,
    input wire stxe_pkg::stxe_op_t op,
    input wire logic [7:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] imm,
    input wire logic [7:0] table_pointer,
    input wire logic [ROM_AW-9:0] pc_page,
    input wire logic [15:0] rom_rdata,
    output logic instr_ready_ff,
    output logic discard_ff,
    output logic [7:0] acc_ff,
    output logic zero_ff,
    output logic [7:0] table_high_byte_latch_ff,
    output logic mem_we_ff,
    output logic [7:0] mem_waddr_ff,
    output logic [7:0] mem_wdata_ff,
    output logic rom_rd_ff,
    output logic [ROM_AW-1:0] rom_addr_ff
);
    // ==========================================================
    // Data path
    stxe_pkg::stxe_state_t state_ff;
    stxe_pkg::stxe_state_t nxt_state;
    logic nxt_instr_ready;
    logic nxt_discard;
    logic [7:0] nxt_acc;
    logic nxt_zero;
    logic [7:0] nxt_table_high_byte_latch;
    logic nxt_mem_we;
    logic [7:0] nxt_mem_waddr;
    logic [7:0] nxt_mem_wdata;
    logic nxt_rom_rd;
    logic [ROM_AW-1:0] nxt_rom_addr;
    logic [7:0] alu_result;
    logic alu_skip;
    logic alu_zero;
    logic take;

    assign take = op_valid & instr_ready_ff;

    stxe_logic_unit u_alu (
        .op(op),
        .acc(acc_ff),
        .mem(mem_rdata),
        .imm(imm),
        .bit_sel(bit_sel),
        .result(alu_result),
        .skip_cond(alu_skip),
        .result_zero(alu_zero)
    );

    // ==========================================================
    // Sequencer
    // Decode must hold off while ready is low; requests then are ignored
    always_comb begin
        nxt_state = state_ff;
        nxt_discard = 1'b0;
        nxt_acc = acc_ff;
        nxt_zero = zero_ff;
        nxt_table_high_byte_latch = table_high_byte_latch_ff;
        nxt_mem_we = 1'b0;
        nxt_mem_waddr = mem_waddr_ff;
        nxt_mem_wdata = mem_wdata_ff;
        nxt_rom_rd = 1'b0;
        nxt_rom_addr = rom_addr_ff;
        unique case (state_ff)
            stxe_pkg::ST_RUN: begin
                if (take) begin
                    unique case (op)
                        stxe_pkg::OP_NIBX: nxt_acc = alu_result;
                        stxe_pkg::OP_SKZ, stxe_pkg::OP_SKZA,
                        stxe_pkg::OP_SKBIT: begin
                            if (op == stxe_pkg::OP_SKZA) begin
                                nxt_acc = mem_rdata;
                            end
                            if (alu_skip) begin
                                nxt_discard = 1'b1;
                                nxt_state = stxe_pkg::ST_DUMMY;
                            end
                        end
                        stxe_pkg::OP_TRDC, stxe_pkg::OP_TRDL: begin
                            // ROM port is busy next cycle, so decode stalls
                            nxt_rom_rd = 1'b1;
                            nxt_mem_waddr = mem_addr;
                            if (op == stxe_pkg::OP_TRDL) begin
                                nxt_rom_addr = {{(ROM_AW-8){1'b1}},
                                    table_pointer};
                            end else begin
                                nxt_rom_addr = {pc_page,
                                    table_pointer};
                            end
                            nxt_state = stxe_pkg::ST_TABLE;
                        end
                        stxe_pkg::OP_XOR_TO_MEM: begin
                            nxt_mem_we = 1'b1;
                            nxt_mem_waddr = mem_addr;
                            nxt_mem_wdata = alu_result;
                            nxt_zero = alu_zero;
                        end
                        stxe_pkg::OP_XORA, stxe_pkg::OP_XORI: begin
                            nxt_acc = alu_result;
                            nxt_zero = alu_zero;
                        end
                        default: nxt_state = stxe_pkg::ST_RUN;
                    endcase
                end
            end
            stxe_pkg::ST_TABLE: begin
                nxt_mem_we = 1'b1;
                nxt_mem_wdata = rom_rdata[7:0];
                nxt_table_high_byte_latch = rom_rdata[15:8];
                nxt_state = stxe_pkg::ST_RUN;
            end
            stxe_pkg::ST_DUMMY: nxt_state = stxe_pkg::ST_RUN;
            default: nxt_state = stxe_pkg::ST_RUN;
        endcase
        nxt_instr_ready = (nxt_state == stxe_pkg::ST_RUN);
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_ff <= stxe_pkg::ST_RUN;
            instr_ready_ff <= 1'b1;
            discard_ff <= 1'b0;
            acc_ff <= `STXE_ACC_RST;
            zero_ff <= `STXE_ZERO_RST;
            table_high_byte_latch_ff <= `STXE_LATCH_RST;
            mem_we_ff <= 1'b0;
            mem_waddr_ff <= 8'h00;
            mem_wdata_ff <= 8'h00;
            rom_rd_ff <= 1'b0;
            rom_addr_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            instr_ready_ff <= nxt_instr_ready;
            discard_ff <= nxt_discard;
            acc_ff <= nxt_acc;
            zero_ff <= nxt_zero;
            table_high_byte_latch_ff <= nxt_table_high_byte_latch;
            mem_we_ff <= nxt_mem_we;
            mem_waddr_ff <= nxt_mem_waddr;
            mem_wdata_ff <= nxt_mem_wdata;
            rom_rd_ff <= nxt_rom_rd;
            rom_addr_ff <= nxt_rom_addr;
        end
    end

    // ==========================================================
    // Assertions
    property p_nibx;
        @(posedge mclk) disable iff (!resetn)
        take && op == stxe_pkg::OP_NIBX |=>
            acc_ff == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}
            && $stable(zero_ff) && !mem_we_ff;
    endproperty
    a_nibx: assert property (p_nibx)
        else $error("nibble exchange wrong");

    property p_skz_taken;
        @(posedge mclk) disable iff (!resetn)
        take && op == stxe_pkg::OP_SKZ && mem_rdata == 8'h00 |=>
            discard_ff && !instr_ready_ff && $stable(zero_ff)
            ##1 instr_ready_ff && !discard_ff;
    endproperty
    a_skz_taken: assert property (p_skz_taken)
        else $error("skip not taken");

    property p_skz_not;
        @(posedge mclk) disable iff (!resetn)
        take && op == stxe_pkg::OP_SKZ && mem_rdata != 8'h00 |=>
            !discard_ff && instr_ready_ff && $stable(acc_ff);
    endproperty
    a_skz_not: assert property (p_skz_not)
        else $error("false skip");

    property p_skza;
        @(posedge mclk) disable iff (!resetn)
        take && op == stxe_pkg::OP_SKZA |=>
            acc_ff == $past(mem_rdata)
            && discard_ff == (acc_ff == 8'h00) && $stable(zero_ff);
    endproperty
    a_skza: assert property (p_skza)
        else $error("move test skip wrong");

    property p_skbit;
        @(posedge mclk) disable iff (!resetn)
        take && op == stxe_pkg::OP_SKBIT |=>
            discard_ff == !$past(mem_rdata[bit_sel]) && !mem_we_ff;
    endproperty
    a_skbit: assert property (p_skbit)
        else $error("bit skip wrong");

    property p_trdc;
        @(posedge mclk) disable iff (!resetn)
        take && op == stxe_pkg::OP_TRDC |=>
            rom_rd_ff && !instr_ready_ff
            && rom_addr_ff == {$past(pc_page), $past(table_pointer)}
            ##1 mem_we_ff && instr_ready_ff
            && mem_wdata_ff == $past(rom_rdata[7:0])
            && table_high_byte_latch_ff == $past(rom_rdata[15:8]);
    endproperty
    a_trdc: assert property (p_trdc)
        else $error("table read wrong");

    property p_trdl;
        @(posedge mclk) disable iff (!resetn)
        take && op == stxe_pkg::OP_TRDL |=>
            rom_addr_ff == {{(ROM_AW-8){1'b1}}, $past(table_pointer)}
            ##1 mem_we_ff && mem_waddr_ff == $past(mem_addr, 2);
    endproperty
    a_trdl: assert property (p_trdl)
        else $error("last page read wrong");

    property p_xora;
        @(posedge mclk) disable iff (!resetn)
        take && op == stxe_pkg::OP_XORA |=>
            acc_ff == ($past(acc_ff) ^ $past(mem_rdata))
            && zero_ff == (acc_ff == 8'h00) && !mem_we_ff;
    endproperty
    a_xora: assert property (p_xora)
        else $error("xor to acc wrong");

    property p_xor_to_mem;
        @(posedge mclk) disable iff (!resetn)
        take && op == stxe_pkg::OP_XOR_TO_MEM |=>
            mem_we_ff && $stable(acc_ff)
            && mem_wdata_ff == ($past(acc_ff) ^ $past(mem_rdata))
            && zero_ff == (mem_wdata_ff == 8'h00);
    endproperty
    a_xor_to_mem: assert property (p_xor_to_mem)
        else $error("xor to memory wrong");

    property p_xori;
        @(posedge mclk) disable iff (!resetn)
        take && op == stxe_pkg::OP_XORI |=>
            acc_ff == ($past(acc_ff) ^ $past(imm))
            && zero_ff == (acc_ff == 8'h00);
    endproperty
    a_xori: assert property (p_xori)
        else $error("xor immediate wrong");

    property p_zero_hold;
        @(posedge mclk) disable iff (!resetn)
        !(take && (op == stxe_pkg::OP_XORA || op == stxe_pkg::OP_XOR_TO_MEM
            || op == stxe_pkg::OP_XORI)) |=> $stable(zero_ff);
    endproperty
    a_zero_hold: assert property (p_zero_hold)
        else $error("zero flag moved");

    property p_table_len;
        @(posedge mclk) disable iff (!resetn)
        rom_rd_ff |-> !instr_ready_ff ##1 instr_ready_ff;
    endproperty
    a_table_len: assert property (p_table_len)
        else $error("table too long");
endmodule

// ---- stxe_exec_tb.sv ----
// Self-checking testbench for the skip, table-read and XOR executor
`timescale 1ns/1ps
module stxe_exec_tb;
    logic mclk, resetn, op_valid, instr_ready_ff, discard_ff, zero_ff;
    logic mem_we_ff, rom_rd_ff;
    stxe_pkg::stxe_op_t op;
    logic [7:0] mem_addr, mem_rdata, imm, table_pointer, acc_ff;
    logic [7:0] table_high_byte_latch_ff, mem_waddr_ff, mem_wdata_ff;
    logic [2:0] bit_sel;
    logic [4:0] pc_page;
    logic [15:0] rom_rdata;
    logic [12:0] rom_addr_ff;
    logic [7:0] exp_acc;
    int bad_count, check_count, cycles;
    stxe_pkg::stxe_op_t skips[3] = '{stxe_pkg::OP_SKZ, stxe_pkg::OP_SKZA,
                                     stxe_pkg::OP_SKBIT};

    stxe_exec u_dut (.mclk(mclk), .resetn(resetn), .op_valid(op_valid),
        .op(op), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .bit_sel(bit_sel), .imm(imm), .table_pointer(table_pointer),
        .pc_page(pc_page), .rom_rdata(rom_rdata),
        .instr_ready_ff(instr_ready_ff), .discard_ff(discard_ff),
        .acc_ff(acc_ff), .zero_ff(zero_ff),
        .table_high_byte_latch_ff(table_high_byte_latch_ff),
        .mem_we_ff(mem_we_ff), .mem_waddr_ff(mem_waddr_ff),
        .mem_wdata_ff(mem_wdata_ff), .rom_rd_ff(rom_rd_ff),
        .rom_addr_ff(rom_addr_ff));

    // ==========================================
    // Clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Whole run is a few dozen cycles; 2000 leaves wide margin
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            end_sim();
        end
    end

    // ==========================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // Inputs move 2 ns after the edge so sampling never races
    task automatic tick();
        @(posedge mclk);
        #2;
    endtask

    task automatic issue(input stxe_pkg::stxe_op_t o, input logic [7:0] m);
        op_valid = 1'b1;
        op = o;
        mem_rdata = m;
        tick();
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_xor();
        imm = 8'h5a;
        issue(stxe_pkg::OP_XORI, 8'h00);
        check(16'(acc_ff), 16'h005a);
        check(16'(zero_ff), 16'h0000);
        issue(stxe_pkg::OP_XORI, 8'h00);
        check(16'(acc_ff), 16'h0000);
        check(16'(zero_ff), 16'h0001);
        issue(stxe_pkg::OP_XORA, 8'h3c);
        check(16'(acc_ff), 16'h003c);
        check(16'(zero_ff), 16'h0000);
        check(16'(mem_we_ff), 16'h0000);
        mem_addr = 8'h21;
        issue(stxe_pkg::OP_XOR_TO_MEM, 8'h3c);
        check(16'(mem_we_ff), 16'h0001);
        check({mem_waddr_ff, mem_wdata_ff}, 16'h2100);
        check(16'(acc_ff), 16'h003c);
        check(16'(zero_ff), 16'h0001);
        issue(stxe_pkg::OP_NIBX, 8'ha5);
        check(16'(acc_ff), 16'h005a);
        check(16'(zero_ff), 16'h0001);
        check(16'(mem_we_ff), 16'h0000);
        exp_acc = 8'h5a;
    endtask

    task automatic t_skip();
        bit_sel = 3'h5;
        imm = 8'hff;
        for (int i = 0; i < 3; i++) begin
            issue(skips[i], (i == 2) ? 8'hdf : 8'h00);
            if (i == 1) begin
                exp_acc = 8'h00;
            end
            check(16'(discard_ff), 16'h0001);
            check(16'(instr_ready_ff), 16'h0000);
            check(16'(acc_ff), 16'(exp_acc));
            // Request during the dummy cycle must be dropped
            issue(stxe_pkg::OP_XORI, 8'h00);
            check(16'(discard_ff), 16'h0000);
            check(16'(instr_ready_ff), 16'h0001);
            check(16'(acc_ff), 16'(exp_acc));
            issue(skips[i], 8'h20);
            if (i == 1) begin
                exp_acc = 8'h20;
            end
            check(16'(discard_ff), 16'h0000);
            check(16'(instr_ready_ff), 16'h0001);
            check(16'(acc_ff), 16'(exp_acc));
            check(16'(zero_ff), 16'h0001);
        end
    endtask

    task automatic t_table();
        logic [15:0] w;
        logic [15:0] exp_addr;
        for (int i = 0; i < 2; i++) begin
            w = (i == 0) ? 16'hb71e : 16'h4ce2;
            exp_addr = (i == 0) ? 16'h0a3e : 16'h1f3e;
            pc_page = 5'h0a;
            table_pointer = 8'h3e;
            mem_addr = 8'h44;
            rom_rdata = ~w;
            issue((i == 0) ? stxe_pkg::OP_TRDC : stxe_pkg::OP_TRDL, 8'h00);
            check(16'(rom_rd_ff), 16'h0001);
            check(16'(rom_addr_ff), exp_addr);
            check(16'(instr_ready_ff), 16'h0000);
            check(16'(mem_we_ff), 16'h0000);
            op_valid = 1'b0;
            rom_rdata = w;
            tick();
            check(16'(mem_we_ff), 16'h0001);
            check({mem_waddr_ff, mem_wdata_ff}, {8'h44, w[7:0]});
            check(16'(table_high_byte_latch_ff), 16'(w[15:8]));
            check(16'(instr_ready_ff), 16'h0001);
            check(16'(rom_rd_ff), 16'h0000);
            check({acc_ff, 7'h00, zero_ff}, {exp_acc, 8'h01});
        end
    endtask

    // ==========================================
    // Main sequence
    initial begin
        resetn = 1'b0;
        op_valid = 1'b0;
        op = stxe_pkg::OP_NIBX;
        {mem_addr, mem_rdata, imm, table_pointer} = 32'h0000_0000;
        bit_sel = 3'h0;
        pc_page = 5'h00;
        rom_rdata = 16'h0000;
        repeat (5) @(posedge mclk);
        #2;
        resetn = 1'b1;
        check({acc_ff, table_high_byte_latch_ff}, 16'h0000);
        check({12'h000, instr_ready_ff, discard_ff, zero_ff, mem_we_ff},
              16'h0008);
        t_xor();
        t_skip();
        t_table();
        end_sim();
    end
endmodule
